/* ees_pkg.sv */
package ees_pkg;
   localparam int MEM_DEPTH = 32768;
   localparam int ID_DEPTH = 64;
   localparam logic [3:0] TYPE_ARRAY = 4'ha;
   localparam logic [3:0] TYPE_IDPAGE = 4'hb;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SEL = 3'b001,
      ST_ADDR_HI = 3'b010,
      ST_ADDR_LO = 3'b011,
      ST_WDATA = 3'b100,
      ST_RDATA = 3'b101
   } ees_state_type;
endpackage

/* ees_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ees_mem #(
   parameter int DEPTH = 32768,
   parameter int AW = 15
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [DEPTH];
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
   end
endmodule
`default_nettype wire

/* ees_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Main array holds 32K bytes.
// - 64 byte identification page, lockable read-only.
// - Transfers start with Start, select byte, ack.
// - Type identifier 1010 or 1011.
// - 1010 array, 1011 id page, else nack.
// - Select bit zero: 1 read, 0 write.
// - Device acks ninth bit of written bytes.
// - Select bits b3..b1 match chip pins.
// - Unconnected chip pins read as zero; the code has no pull-down, so an open pin floats.
// - Write inhibit high blocks all writes.
// - Unconnected write inhibit reads low; the code has no pull-down, so an open pin floats.
// - Inhibit still acks select and address.
// - No bus response during power-on reset.
// - Reset release clears to standby.
// - Reset reassertion stops response immediately.
// - Stop returns device to standby.
// - Address 16 bits, high byte first.
// - High byte then low byte, both acked.
// - Bits timed only by serial clock.
// - Data line open drain, never driven high.
// - Data sampled on serial clock rising edge.
module ees_slave
   import ees_pkg::*;
#(
   parameter int AW = 15
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic chip_sel_pin_0_i,
   input wire logic chip_sel_pin_1_i,
   input wire logic chip_sel_pin_2_i,
   input wire logic write_inhibit_pin_i,
   input wire logic id_lock_i,
   output logic busy_o,
   output logic id_locked_o
);
   import ees_pkg::*;
   // Power-on reset released through two scl flip-flops, cleared at once by rst_n_i.
   logic por_s1_q, por_s2_q;
   always_ff @(posedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         por_s1_q <= 1'b0;
         por_s2_q <= 1'b0;
      end else begin
         por_s1_q <= 1'b1;
         por_s2_q <= por_s1_q;
      end
   end
   logic run;
   assign run = por_s2_q && rst_n_i;
   // Start and stop become toggles, so the bit engine sees each one once.
   logic start_t_q, stop_t_q, start_seen_q, stop_seen_q;
   logic start_ev, stop_pend;
   always_ff @(negedge sda_i or negedge run) begin
      if (!run) begin
         start_t_q <= 1'b0;
      end else if (scl_i) begin
         start_t_q <= !start_t_q;
      end
   end
   always_ff @(posedge sda_i or negedge run) begin
      if (!run) begin
         stop_t_q <= 1'b0;
      end else if (scl_i) begin
         stop_t_q <= !stop_t_q;
      end
   end
   assign start_ev = (start_t_q != start_seen_q);
   // A stop counts at once, although the engine only clears on a later edge.
   assign stop_pend = (stop_t_q != stop_seen_q);
   // The lock is kept on the system clock and carried to the serial side.
   logic lock_m_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         lock_m_q <= 1'b0;
      end else if (id_lock_i) begin
         lock_m_q <= 1'b1;
      end
   end
   logic lk_s1_q, locked_q;
   always_ff @(posedge scl_i or negedge run) begin
      if (!run) begin
         lk_s1_q <= 1'b0;
         locked_q <= 1'b0;
      end else begin
         lk_s1_q <= lock_m_q;
         locked_q <= lk_s1_q;
      end
   end
   // Static pins pass two flip-flops before the decoder reads them.
   logic [3:0] pin_s1_q, pin_s2_q;
   always_ff @(posedge scl_i) begin
      pin_s1_q <= {write_inhibit_pin_i, chip_sel_pin_2_i,
         chip_sel_pin_1_i, chip_sel_pin_0_i};
      pin_s2_q <= pin_s1_q;
   end
   ees_state_type st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [15:0] addr_q;
   logic idp_q, ack_q, mem_we_q;
   logic [7:0] rd_q;
   logic inhibit, in_ack;
   assign inhibit = pin_s2_q[3];
   assign in_ack = (bit_q == BIT_ACK);
   logic [7:0] mrd, idrd;
   logic mwe, iwe;
   assign mwe = mem_we_q && !idp_q;
   assign iwe = mem_we_q && idp_q;
   ees_mem #(.DEPTH(MEM_DEPTH), .AW(AW)) u_arr (
      .clk_i(scl_i),
      .we_i(mwe),
      .addr_i(addr_q[AW-1:0]),
      .wdata_i(sh_q),
      .rdata_o(mrd)
   );
   ees_mem #(.DEPTH(ID_DEPTH), .AW(6)) u_idp (
      .clk_i(scl_i),
      .we_i(iwe),
      .addr_i(addr_q[5:0]),
      .wdata_i(sh_q),
      .rdata_o(idrd)
   );
   // Bit engine clocked only by scl rising edges.
   always_ff @(posedge scl_i or negedge run) begin
      if (!run) begin
         st_q <= ST_IDLE;
         bit_q <= BIT_FIRST;
         sh_q <= 8'h00;
         addr_q <= ADDR_RESET;
         idp_q <= 1'b0;
         ack_q <= 1'b0;
         mem_we_q <= 1'b0;
         start_seen_q <= 1'b0;
         stop_seen_q <= 1'b0;
      end else begin
         mem_we_q <= 1'b0;
         start_seen_q <= start_t_q;
         stop_seen_q <= stop_t_q;
         if (start_ev) begin
            st_q <= ST_SEL;
            bit_q <= BIT_FIRST + 4'h1;
            sh_q <= {sh_q[6:0], sda_i};
            ack_q <= 1'b0;
         end else if (stop_pend) begin
            st_q <= ST_IDLE;
            bit_q <= BIT_FIRST;
            ack_q <= 1'b0;
         end else if (st_q != ST_IDLE) begin
            if (!in_ack) begin
               sh_q <= {sh_q[6:0], sda_i};
               bit_q <= bit_q + 4'h1;
               if (bit_q == 4'h7) begin
                  ack_q <= 1'b0;
                  case (st_q)
                     ST_SEL, ST_IDLE: begin
                        if ((sh_q[6:3] == TYPE_ARRAY
                             || sh_q[6:3] == TYPE_IDPAGE)
                            && sh_q[2:0] == pin_s2_q[2:0]) begin
                           ack_q <= 1'b1;
                           idp_q <= sh_q[3];
                        end
                     end
                     ST_ADDR_HI, ST_ADDR_LO: begin
                        ack_q <= 1'b1;
                     end
                     ST_WDATA: begin
                        ack_q <= !inhibit && !(idp_q && locked_q);
                     end
                     default: begin
                        ack_q <= 1'b0;
                     end
                  endcase
               end
            end else begin
               bit_q <= BIT_FIRST;
               case (st_q)
                  ST_SEL, ST_IDLE: begin
                     if (!ack_q) begin
                        st_q <= ST_IDLE;
                     end else if (sh_q[0]) begin
                        st_q <= ST_RDATA;
                     end else begin
                        st_q <= ST_ADDR_HI;
                     end
                  end
                  ST_ADDR_HI: begin
                     addr_q[15:8] <= sh_q;
                     st_q <= ST_ADDR_LO;
                  end
                  ST_ADDR_LO: begin
                     addr_q[7:0] <= sh_q;
                     st_q <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     if (ack_q) begin
                        mem_we_q <= 1'b1;
                     end
                  end
                  ST_RDATA: begin
                     addr_q <= addr_q + 16'h0001;
                     if (sda_i) begin
                        st_q <= ST_IDLE;
                     end
                  end
                  default: begin
                     st_q <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   end
   always_ff @(posedge scl_i or negedge run) begin
      if (!run) begin
         rd_q <= 8'h00;
      end else begin
         rd_q <= idp_q ? idrd : mrd;
      end
   end
   // Drive on scl falling edge so sda changes while scl is low.
   logic pull_q;
   always_ff @(negedge scl_i or negedge run) begin
      if (!run) begin
         pull_q <= 1'b0;
      end else if (in_ack && st_q != ST_RDATA) begin
         pull_q <= ack_q;
      end else if (st_q == ST_RDATA && !in_ack) begin
         pull_q <= !rd_q[3'h7 - bit_q[2:0]];
      end else begin
         pull_q <= 1'b0;
      end
   end
   assign sda_o = 1'b0;
   assign sda_oe_n_o = !pull_q;
   // Status toward the system clock.
   logic b1_q, b2_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         b1_q <= 1'b0;
         b2_q <= 1'b0;
      end else begin
         b1_q <= (st_q != ST_IDLE) && !stop_pend;
         b2_q <= b1_q;
      end
   end
   assign busy_o = b2_q;
   assign id_locked_o = lock_m_q;
   chk_no_drive_reset: assert property (@(posedge mclk_i)
      !rst_n_i |-> sda_oe_n_o) else $error("sda driven in reset");
   chk_drive_low: assert property (@(posedge mclk_i)
      sda_o == 1'b0) else $error("sda driven high");
   chk_idle_quiet: assert property (@(posedge scl_i) disable iff (!run)
      st_q == ST_IDLE |-> !pull_q) else $error("sda pulled while idle");
   chk_inhibit_nack: assert property (@(posedge scl_i) disable iff (!run)
      (st_q == ST_WDATA && in_ack && inhibit) |-> !ack_q)
      else $error("data acked while inhibited");
   chk_wrong_type: assert property (@(posedge scl_i) disable iff (!run)
      (st_q == ST_SEL && in_ack && sh_q[7:5] != 3'h5) |-> !ack_q)
      else $error("foreign type acked");
   chk_ack_slot: assert property (@(posedge scl_i) disable iff (!run)
      (pull_q && st_q != ST_RDATA) |-> in_ack)
      else $error("ack outside ninth bit");
   cov_busy: cover property (@(posedge mclk_i) $rose(busy_o));
   cov_lock: cover property (@(posedge mclk_i) $rose(id_locked_o));
   cov_pull: cover property (@(posedge mclk_i) !sda_oe_n_o);
endmodule
`default_nettype wire

/* ees_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
module ees_i2c_master (
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Data falls while the clock is high.
   task automatic start;
      #1 sda_low_o = 1'b0;
      #6.5 scl_o = 1'b1;
      #7.5 sda_low_o = 1'b1;
      #7.5 scl_o = 1'b0;
   endtask
   // Data moves only while the clock is low.
   task automatic bit_x(input logic b, output logic r);
      #1 sda_low_o = ~b;
      #6.5 scl_o = 1'b1;
      #7.5 r = sda_i;
      scl_o = 1'b0;
   endtask
   // Most significant bit first, then a released ninth bit.
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   // The master answers each read byte.
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(nack, r);
   endtask
   // Data rises while the clock is high.
   task automatic stop;
      #1 sda_low_o = 1'b1;
      #6.5 scl_o = 1'b1;
      #7.5 sda_low_o = 1'b0;
   endtask
endmodule
`default_nettype wire

/* ees_slave_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ees_slave_tb;
   import ees_pkg::*;
   logic mclk_i, rst_n_i, sda_o, sda_oe_n_o, busy_o, id_locked_o;
   logic scl, sda_low, wi, lk, k;
   logic [2:0] cs;
   logic [3:0] a;
   logic [7:0] d;
   int errors = 0;
   int tests_run = 0;
   wire logic sda;
   // The line is pulled up; either party may pull it low.
   assign sda = ~(sda_low | (~sda_oe_n_o & ~sda_o));
   ees_i2c_master m (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
   ees_slave DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
      .chip_sel_pin_0_i(cs[0]), .chip_sel_pin_1_i(cs[1]),
      .chip_sel_pin_2_i(cs[2]), .write_inhibit_pin_i(wi),
      .id_lock_i(lk), .busy_o(busy_o), .id_locked_o(id_locked_o));
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("Compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task wr(input logic [7:0] sel, input logic [15:0] ad, input logic [7:0] dt);
      m.start();
      m.wbyte(sel, a[3]);
      m.wbyte(ad[15:8], a[2]);
      m.wbyte(ad[7:0], a[1]);
      m.wbyte(dt, a[0]);
      m.stop();
   endtask
   task rd(input logic [7:0] sel, input logic [15:0] ad);
      m.start();
      m.wbyte(sel, a[3]);
      m.wbyte(ad[15:8], a[2]);
      m.wbyte(ad[7:0], a[1]);
      m.start();
      m.wbyte(sel | 8'h01, a[0]);
      m.rbyte(1'b1, d);
      m.stop();
   endtask
   // The serial side leaves reset only after two serial clock edges.
   task wake;
      repeat (3) m.bit_x(1'b1, k);
      m.stop();
   endtask
   task setp(input logic [2:0] c, input logic w, input logic l);
      @(posedge mclk_i);
      cs <= c;
      wi <= w;
      lk <= l;
      repeat (2) @(posedge mclk_i);
   endtask
   initial begin
      #2000000;
      errors++;
      print_verdict();
   end
   initial begin
      rst_n_i = 1'b0;
      cs = 3'h0;
      wi = 1'b0;
      lk = 1'b0;
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      wake();
      setp(3'h5, 1'b0, 1'b0);
      wr(8'haa, 16'h1234, 8'h5c);
      chk(a, 8'h0f);
      rd(8'haa, 16'h1234);
      chk(a, 8'h0f);
      chk(d, 8'h5c);
      wr(8'ha8, 16'h1234, 8'h11);
      chk(a, 8'h00);
      wr(8'h9a, 16'h1234, 8'h11);
      chk(a, 8'h00);
      $display("Test 1 done");
      m.start();
      m.wbyte(8'haa, k);
      repeat (4) @(posedge mclk_i);
      chk(busy_o, 8'h01);
      m.stop();
      repeat (4) @(posedge mclk_i);
      chk(busy_o, 8'h00);
      $display("Test 2 done");
      setp(3'h5, 1'b1, 1'b0);
      wr(8'haa, 16'h1234, 8'h77);
      chk(a, 8'h0e);
      rd(8'haa, 16'h1234);
      chk(d, 8'h5c);
      $display("Test 3 done");
      setp(3'h5, 1'b0, 1'b0);
      wr(8'hba, 16'h0005, 8'h3c);
      chk(a, 8'h0f);
      setp(3'h5, 1'b0, 1'b1);
      setp(3'h5, 1'b0, 1'b0);
      chk(id_locked_o, 8'h01);
      wr(8'hba, 16'h0005, 8'hc3);
      chk(a, 8'h0e);
      rd(8'hba, 16'h0005);
      chk(d, 8'h3c);
      $display("Test 4 done");
      m.start();
      m.wbyte(8'haa, k);
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      m.wbyte(8'h12, k);
      chk(k, 8'h00);
      m.stop();
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      wake();
      chk(busy_o, 8'h00);
      rd(8'haa, 16'h1234);
      chk(a, 8'h0f);
      chk(d, 8'h5c);
      $display("Test 5 done");
      print_verdict();
   end
endmodule
`default_nettype wire
